// ---- pkg/vs_pkg.sv ----
// constants and types shared by the valley-skip switch-on control block
package vs_pkg;
	localparam int CNT_W = 24;
	localparam int CLK_PERIOD_NS = 4;

	// soft-start: total time and number of equal steps
	localparam int SOFTSTART_MS = 12;
	localparam int SS_STEPS = 4;
	localparam logic [CNT_W-1:0] SS_STEP_CYC =
		CNT_W'((SOFTSTART_MS * 1_000_000 / SS_STEPS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] SS_LAST = 2'(SS_STEPS - 1);

	// peak current-sense limit in millivolts
	localparam logic [9:0] CS_INIT_MV = 10'h140;
	localparam logic [9:0] CS_FINAL_MV = 10'h3e8;
	localparam logic [9:0] CS_SPAN_MV = CS_FINAL_MV - CS_INIT_MV;

	// feedback evaluation period of the skip counter
	localparam int EVAL_MS = 48;
	localparam logic [CNT_W-1:0] EVAL_CYC =
		CNT_W'((EVAL_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ringing suppression (least time, rounded up)
	localparam int RING_NS = 2500;
	localparam logic [CNT_W-1:0] RING_CYC =
		CNT_W'((RING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// maximum off time (longest time, rounded down)
	localparam int MAX_OFF_NS = 50000;
	localparam logic [CNT_W-1:0] MAX_OFF_CYC = CNT_W'(MAX_OFF_NS / CLK_PERIOD_NS);
	// overvoltage blanking (least time, rounded up)
	localparam int OVP_BLANK_NS = 1000;
	localparam logic [CNT_W-1:0] OVP_BLANK_CYC =
		CNT_W'((OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	// skip and valley counter bounds
	localparam logic [2:0] SKIP_MIN = 3'h1;
	localparam logic [2:0] SKIP_MAX = 3'h7;
	localparam logic [2:0] VALLEY_MIN = 3'h0;
	localparam logic [2:0] VALLEY_MAX = 3'h7;

	// comparator input bit positions on the synchroniser bus
	localparam int IN_W = 8;
	localparam int IN_SUPPLY = 0;
	localparam int IN_FB_LOW = 1;
	localparam int IN_FB_HIGH = 2;
	localparam int IN_FB_RST = 3;
	localparam int IN_LINE_HIGH = 4;
	localparam int IN_AUX_BELOW = 5;
	localparam int IN_AUX_OVP = 6;
	localparam int IN_CS_OFF = 7;

	typedef enum logic [1:0] {
		VS_PRECHARGE = 2'b00,
		VS_SOFTSTART = 2'b01,
		VS_RUN = 2'b10,
		VS_LATCHED = 2'b11
	} vs_phase_e;
endpackage

// ---- verilog/vs_sync.sv ----
// two-flop synchroniser for a bus of independent comparator levels
`timescale 1ns/10ps
module vs_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} vs_sync_s;

	vs_sync_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = d_i;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.sync;
endmodule

// ---- verilog/vs_tick.sv ----
// period tick generator, one-cycle pulse every PERIOD enabled cycles
`timescale 1ns/10ps
module vs_tick
	import vs_pkg::*;
#(
	parameter logic [vs_pkg::CNT_W-1:0] PERIOD = vs_pkg::CNT_ONE
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic run_i,
	output logic tick_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
	} vs_tick_s;

	vs_tick_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run_i) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= PERIOD - CNT_ONE) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + CNT_ONE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;
endmodule

// ---- verilog/vs_core.sv ----
// valley-skip switch-on control: soft-start, skip counter, valley counter, ovp latch
// What this block does
// [RULE1] soft-start is a digital timed sequence of 12 ms in 4 equal steps
// [RULE2] peak current limit rises stepwise from 0.32 V to 1 V during soft-start
// [RULE3] above supply turn-on threshold, startup cell turns off and soft-start begins
// [RULE4] feedback is judged against thresholds once every 48 ms, skip counter updated
// [RULE5] feedback always below low threshold: skip counter counts up, stops at 7
// [RULE6] feedback above low but never above high threshold: skip counter holds
// [RULE7] feedback above high but never above reset threshold: skip counter counts down to 1
// [RULE8] feedback ever above fast-reset threshold: skip counter forced to 1
// [RULE9] skip counter stays within 1..7, steps outside that range ignored
// [RULE10] skip counter starts at 1 after start-up
// [RULE11] hysteresis threshold pair is selected by sensed line voltage level
// [RULE12] valley counter holds 0..7 and never counts past 7
// [RULE13] after switch-off, each falling auxiliary crossing adds one to valley counter
// [RULE14] valley counter clears whenever gate drive goes from low to high
// [RULE15] auxiliary overvoltage in off-time latches off permanently after blanking time
// [RULE16] skip count sets how many valleys are passed before switching on again
// [RULE17] after ringing suppression, gate turns on when valley count reaches skip count
// [RULE18] gate turns on after maximum off time regardless of counters and aux input
// [RULE19] gate cannot go high again until ringing suppression time after going low
// [RULE20] feedback crossings are sticky per period and reloaded from the update-cycle sample after each update
`timescale 1ns/10ps
module vs_core
	import vs_pkg::*;
#(
	parameter logic [vs_pkg::CNT_W-1:0] SS_STEP_CYC = vs_pkg::SS_STEP_CYC,
	parameter logic [vs_pkg::CNT_W-1:0] EVAL_CYC = vs_pkg::EVAL_CYC,
	parameter logic [vs_pkg::CNT_W-1:0] MAX_OFF_CYC = vs_pkg::MAX_OFF_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic supply_above_on_i,
	input wire logic fb_above_low_i,
	input wire logic fb_above_high_i,
	input wire logic fb_above_reset_i,
	input wire logic line_high_i,
	input wire logic aux_valley_i,
	input wire logic aux_overvoltage_i,
	input wire logic cs_off_i,
	output logic startup_cell_en_o,
	output logic [9:0] cs_limit_mv_o,
	output logic hyst_sel_o,
	output logic gate_drive_output_o,
	output logic [2:0] skip_count_o,
	output logic [2:0] valley_count_o,
	output logic latched_off_o,
	output vs_pkg::vs_phase_e phase_o
);
	import vs_pkg::*;

	typedef struct packed {
		vs_phase_e phase;
		logic [1:0] ss_step;
		logic [9:0] cs_lim;
		logic [2:0] skip;
		logic seen_low;
		logic seen_high;
		logic seen_rst;
		logic hyst_sel;
		logic gate;
		logic [CNT_W-1:0] off_cnt;
		logic [2:0] valley;
		logic below_prev;
		logic [CNT_W-1:0] ovp_cnt;
	} vs_core_s;

	vs_core_s s_q, s_d;
	logic [IN_W-1:0] in_s;
	logic ss_tick;
	logic eval_tick;
	logic active;
	logic valley_edge;
	logic turn_on;

	function automatic logic [9:0] cs_step_limit(input logic [1:0] step);
		logic [11:0] t;
		t = 12'(step) * 12'(CS_SPAN_MV) / 12'(SS_LAST);
		return CS_INIT_MV + t[9:0];
	endfunction

	// comparators and line sense come from the analog side, asynchronous to clk_i
	vs_sync #(
		.W(IN_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.d_i({cs_off_i, aux_overvoltage_i, aux_valley_i, line_high_i,
			fb_above_reset_i, fb_above_high_i, fb_above_low_i, supply_above_on_i}),
		.q_o(in_s)
	);

	vs_tick #(
		.PERIOD(SS_STEP_CYC)
	) u_ss_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.run_i(s_q.phase == VS_SOFTSTART),
		.tick_o(ss_tick)
	);

	vs_tick #(
		.PERIOD(EVAL_CYC)
	) u_eval_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.run_i(active),
		.tick_o(eval_tick)
	);

	assign active = (s_q.phase == VS_SOFTSTART) || (s_q.phase == VS_RUN);
	// aux_valley_i is high while the delayed aux voltage sits below the detect level
	assign valley_edge = in_s[IN_AUX_BELOW] && !s_q.below_prev;
	// the analog switch-off request only matters while the gate is high
	assign turn_on = active && !s_q.gate &&
		(((s_q.off_cnt >= RING_CYC) && (s_q.valley >= s_q.skip)) || // see [RULE17] [RULE16]
		(s_q.off_cnt >= MAX_OFF_CYC)); // see [RULE18]

	always_comb begin
		s_d = s_q;
		s_d.below_prev = in_s[IN_AUX_BELOW];
		s_d.hyst_sel = in_s[IN_LINE_HIGH]; // see [RULE11]

		unique case (s_q.phase)
			VS_PRECHARGE: begin
				if (in_s[IN_SUPPLY]) begin
					s_d.phase = VS_SOFTSTART; // see [RULE3]
					s_d.ss_step = '0;
					s_d.cs_lim = CS_INIT_MV;
					s_d.skip = SKIP_MIN; // see [RULE10]
				end
			end
			VS_SOFTSTART: begin
				if (ss_tick) begin
					if (s_q.ss_step == SS_LAST) begin
						s_d.phase = VS_RUN; // see [RULE1]
						s_d.cs_lim = CS_FINAL_MV;
					end else begin
						s_d.ss_step = s_q.ss_step + 2'h1;
						s_d.cs_lim = cs_step_limit(s_q.ss_step + 2'h1); // see [RULE2]
					end
				end
			end
			VS_RUN: begin
				s_d.cs_lim = CS_FINAL_MV;
			end
			VS_LATCHED: begin
				s_d.gate = 1'b0;
			end
		endcase

		// skip counter evaluation
		if (active) begin
			if (eval_tick) begin // see [RULE4]
				if (s_q.seen_rst) begin
					s_d.skip = SKIP_MIN; // see [RULE8]
				end else if (s_q.seen_high) begin
					if (s_q.skip > SKIP_MIN) begin // see [RULE9]
						s_d.skip = s_q.skip - 3'h1; // see [RULE7]
					end
				end else if (s_q.seen_low) begin
					s_d.skip = s_q.skip; // see [RULE6]
				end else if (s_q.skip < SKIP_MAX) begin // see [RULE9]
					s_d.skip = s_q.skip + 3'h1; // see [RULE5]
				end
				// a crossing seen on the update cycle opens the next period
				s_d.seen_low = in_s[IN_FB_LOW]; // see [RULE20]
				s_d.seen_high = in_s[IN_FB_HIGH];
				s_d.seen_rst = in_s[IN_FB_RST];
			end else begin
				s_d.seen_low = s_q.seen_low || in_s[IN_FB_LOW]; // see [RULE20]
				s_d.seen_high = s_q.seen_high || in_s[IN_FB_HIGH];
				s_d.seen_rst = s_q.seen_rst || in_s[IN_FB_RST];
			end
		end else begin
			s_d.seen_low = 1'b0;
			s_d.seen_high = 1'b0;
			s_d.seen_rst = 1'b0;
		end

		// gate, off-time and valley counting
		if (active) begin
			if (s_q.gate) begin
				if (in_s[IN_CS_OFF]) begin
					s_d.gate = 1'b0;
					s_d.off_cnt = '0; // see [RULE19]
				end
			end else if (turn_on) begin
				s_d.gate = 1'b1;
				s_d.valley = VALLEY_MIN; // see [RULE14]
			end else begin
				if (s_q.off_cnt != CNT_MAX) begin
					s_d.off_cnt = s_q.off_cnt + CNT_ONE;
				end
				if (valley_edge && s_q.valley < VALLEY_MAX) begin // see [RULE12]
					s_d.valley = s_q.valley + 3'h1; // see [RULE13]
				end
			end
		end

		// overvoltage needs a continuous blanking interval before the latch
		if (active && !s_q.gate && in_s[IN_AUX_OVP]) begin
			if (s_q.ovp_cnt >= OVP_BLANK_CYC - CNT_ONE) begin
				s_d.phase = VS_LATCHED; // see [RULE15]
				s_d.gate = 1'b0;
			end else begin
				s_d.ovp_cnt = s_q.ovp_cnt + CNT_ONE;
			end
		end else begin
			s_d.ovp_cnt = '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '{phase: VS_PRECHARGE, ss_step: 2'h0, cs_lim: CS_INIT_MV,
				skip: SKIP_MIN, seen_low: 1'b0, seen_high: 1'b0, seen_rst: 1'b0,
				hyst_sel: 1'b0, gate: 1'b0, off_cnt: '0, valley: VALLEY_MIN,
				below_prev: 1'b0, ovp_cnt: '0};
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	// the startup cell is a level of the phase; it never comes back once running
	assign startup_cell_en_o = (s_q.phase == VS_PRECHARGE); // see [RULE3]
	assign cs_limit_mv_o = s_q.cs_lim;
	assign hyst_sel_o = s_q.hyst_sel;
	assign gate_drive_output_o = s_q.gate;
	assign skip_count_o = s_q.skip;
	assign valley_count_o = s_q.valley;
	assign latched_off_o = (s_q.phase == VS_LATCHED);
	assign phase_o = s_q.phase;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence gate_fell_s;
		clk_en_i && s_q.gate && in_s[IN_CS_OFF] && active && !s_d.gate;
	endsequence

	sequence off_short_s;
		!s_q.gate && s_q.off_cnt < RING_CYC;
	endsequence

	sequence ovp_blanked_s;
		clk_en_i && active && !s_q.gate && in_s[IN_AUX_OVP] &&
			s_q.ovp_cnt >= OVP_BLANK_CYC - CNT_ONE;
	endsequence

	skip_range_a: assert property (s_q.skip >= SKIP_MIN && s_q.skip <= SKIP_MAX) // see [RULE9]
		else $error("skip counter left its range");

	skip_reset_a: assert property ( // see [RULE8]
		clk_en_i && active && eval_tick && s_q.seen_rst |=> s_q.skip == SKIP_MIN)
		else $error("fast reset did not set skip counter to minimum");

	skip_up_a: assert property ( // see [RULE5]
		clk_en_i && active && eval_tick && !s_q.seen_low && !s_q.seen_high && !s_q.seen_rst
		&& s_q.skip < SKIP_MAX |=> s_q.skip == $past(s_q.skip) + 3'h1)
		else $error("skip counter did not count up");

	skip_down_a: assert property ( // see [RULE7]
		clk_en_i && active && eval_tick && s_q.seen_high && !s_q.seen_rst
		&& s_q.skip > SKIP_MIN |=> s_q.skip == $past(s_q.skip) - 3'h1)
		else $error("skip counter did not count down");

	skip_hold_a: assert property ( // see [RULE4]
		clk_en_i && active && !eval_tick |=> $stable(s_q.skip))
		else $error("skip counter moved between evaluations");

	skip_keep_a: assert property ( // see [RULE6]
		clk_en_i && active && eval_tick && s_q.seen_low && !s_q.seen_high && !s_q.seen_rst
		|=> $stable(s_q.skip))
		else $error("skip counter moved in the hold band");

	valley_clear_a: assert property ( // see [RULE14]
		$rose(s_q.gate) |-> s_q.valley == VALLEY_MIN)
		else $error("valley counter not cleared on gate rise");

	ring_hold_a: assert property ( // see [RULE19]
		gate_fell_s ##1 off_short_s |=> !s_q.gate)
		else $error("gate rose inside ringing suppression");

	max_off_a: assert property ( // see [RULE18]
		clk_en_i && active && !s_q.gate && s_q.off_cnt >= MAX_OFF_CYC && !in_s[IN_AUX_OVP]
		|=> s_q.gate)
		else $error("maximum off time did not force the gate on");

	ovp_latch_a: assert property ( // see [RULE15]
		ovp_blanked_s |=> latched_off_o && !s_q.gate ##1 latched_off_o)
		else $error("overvoltage did not latch off");

	startup_off_a: assert property ( // see [RULE3]
		$past(s_q.phase) == VS_PRECHARGE && s_q.phase == VS_SOFTSTART
		|-> !startup_cell_en_o && s_q.cs_lim == CS_INIT_MV && s_q.skip == SKIP_MIN)
		else $error("soft-start entry wrong");

	ss_final_a: assert property ( // see [RULE2]
		s_q.phase == VS_RUN |-> s_q.cs_lim == CS_FINAL_MV)
		else $error("current limit not final after soft-start");
endmodule

// ---- verif/vs_stage_model.sv ----
// behavioural power stage: current ramp, delayed aux ringing, overvoltage
`timescale 1ns/10ps
module vs_stage_model (
	input wire logic clk_i,
	input wire logic gate_i,
	input wire logic [3:0] valleys_i,
	input wire logic [7:0] gap_i,
	input wire logic [9:0] ovp_len_i,
	output logic cs_off_o,
	output logic aux_valley_o,
	output logic aux_overvoltage_o
);
	int on_n = 0;
	int off_n = 0;
	int g;
	assign g = int'(gap_i);
	always @(posedge clk_i) begin
		on_n <= gate_i ? on_n + 1 : 0;
		off_n <= gate_i ? 0 : off_n + 1;
	end
	assign cs_off_o = gate_i && on_n >= 40;
	// aux is clamped below the detect level in on-time, so only off-time edges count
	assign aux_valley_o = gate_i || (off_n >= 100 && (off_n - 100) % g < g / 3
		&& (off_n - 100) / g < int'(valleys_i));
	assign aux_overvoltage_o = !gate_i && off_n >= 10 && off_n < 10 + int'(ovp_len_i);
endmodule

// ---- verif/tb.sv ----
// self-checking bench of the valley-skip switch-on control core
`timescale 1ns/10ps
module tb;
	import vs_pkg::*;
	// shortened counts keep the run small
	localparam logic [CNT_W-1:0] STEP = 24'h14;
	localparam logic [CNT_W-1:0] EVAL = 24'h190;
	localparam logic [CNT_W-1:0] OFFMAX = 24'h5dc;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic supply = 1'b0;
	logic line_high = 1'b0;
	logic [1:0] cat = 2'h0;
	logic [3:0] valleys = 4'h7;
	logic [7:0] gap = 8'h96;
	logic [9:0] ovp_len = 10'h0;
	logic cs_off, aux_valley, aux_ovp, cell_en, hyst_sel, gate, latched;
	logic [9:0] cs_mv;
	logic [2:0] skip, valley;
	vs_phase_e phase;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h0968;
	always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	vs_core #(.SS_STEP_CYC(STEP), .EVAL_CYC(EVAL), .MAX_OFF_CYC(OFFMAX)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
		.supply_above_on_i(supply), .fb_above_low_i(cat != 2'h0),
		.fb_above_high_i(cat[1]), .fb_above_reset_i(cat == 2'h3),
		.line_high_i(line_high), .aux_valley_i(aux_valley),
		.aux_overvoltage_i(aux_ovp), .cs_off_i(cs_off),
		.startup_cell_en_o(cell_en), .cs_limit_mv_o(cs_mv), .hyst_sel_o(hyst_sel),
		.gate_drive_output_o(gate), .skip_count_o(skip), .valley_count_o(valley),
		.latched_off_o(latched), .phase_o(phase));
	vs_stage_model stage (.clk_i(clk_i), .gate_i(gate), .valleys_i(valleys), .gap_i(gap),
		.ovp_len_i(ovp_len), .cs_off_o(cs_off), .aux_valley_o(aux_valley),
		.aux_overvoltage_o(aux_ovp));
	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("MISMATCH %0t: %s", $time, m);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// categories are ordered by priority, so a mixed period acts as the larger one
	function automatic logic [2:0] nsk(input logic [2:0] s, input logic [1:0] c);
		case (c)
			2'h0: return (s == SKIP_MAX) ? s : s + 3'h1;
			2'h1: return s;
			2'h2: return (s == SKIP_MIN) ? s : s - 3'h1;
			default: return SKIP_MIN;
		endcase
	endfunction
	// linear steps from the initial to the final limit, truncated
	function automatic logic [9:0] ss_mv(input int k);
		return CS_INIT_MV + 10'(k * int'(CS_SPAN_MV) / (SS_STEPS - 1));
	endfunction
	int off_cyc = 0;
	int ready = 0;
	int rises = 0;
	logic gate_q = 1'b0;
	logic fell = 1'b0;
	logic [2:0] valley_q = 3'h0;
	logic [2:0] skip_q = 3'h1;
	logic en_q = 1'b1;
	// the first switch-on may use time counted before start, so wait for a fall
	always @(posedge clk_i) begin
		gate_q <= gate;
		valley_q <= valley;
		skip_q <= skip;
		// a sample taken after a frozen edge repeats the one before it
		en_q <= clk_en_i;
		if (rst_i || !(phase === VS_SOFTSTART || phase === VS_RUN)) begin
			off_cyc <= 0;
			ready <= 0;
			fell <= 1'b0;
		end else if (en_q) begin
			off_cyc <= (gate === 1'b1) ? 0 : off_cyc + 1;
			ready <= (gate === 1'b0 && valley >= skip && off_cyc >= RING_CYC) ? ready + 1 : 0;
			if (gate === 1'b0 && gate_q === 1'b1)
				fell <= 1'b1;
			if (gate === 1'b1 && gate_q === 1'b0) begin
				rises <= rises + 1;
				check(valley === VALLEY_MIN, "valley kept");
				if (fell)
					check(off_cyc >= RING_CYC, "on in ringing");
				if (fell)
					check(valley_q >= skip_q || off_cyc >= OFFMAX - 1, "early");
			end else begin
				check({1'b0, valley} - {1'b0, valley_q} <= 4'h1, "step");
			end
			if (ready > 4)
				check(1'b0, "on late");
			if (fell && off_cyc > OFFMAX + 3)
				check(1'b0, "off too long");
		end
		if (latched === 1'b1 && gate !== 1'b0)
			check(1'b0, "on while latched");
	end
	initial begin
		logic [2:0] exp;
		logic [2:0] vm;
		logic [1:0] prev;
		logic [1:0] nxt;
		logic [9:0] mv;
		int t;
		int r;
		logic [19:0] frz;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check(cell_en === 1'b1 && cs_mv === CS_INIT_MV && phase === VS_PRECHARGE, "rst");
		check(skip === SKIP_MIN && valley === VALLEY_MIN && gate === 1'b0, "rst cnt");
		@(posedge clk_i);
		supply <= 1'b1;
		for (t = 0; t < 8 && phase !== VS_SOFTSTART; t++)
			@(posedge clk_i);
		#1;
		check(phase === VS_SOFTSTART && cell_en === 1'b0 && cs_mv === CS_INIT_MV, "ss in");
		for (int k = 1; k <= SS_STEPS; k++) begin
			mv = cs_mv;
			t = 0;
			while (cs_mv === mv && phase === VS_SOFTSTART && t < 40) begin
				@(posedge clk_i);
				#1;
				t++;
			end
			check(t >= STEP - 1 && t <= STEP + 1, "ss step time");
			if (k < SS_STEPS)
				check(cs_mv === ss_mv(k), "ss lvl");
			else
				check(phase === VS_RUN && cs_mv === CS_FINAL_MV, "ss end");
		end
		$display("test soft-start done");
		for (t = 0; t < 2 * EVAL && skip === SKIP_MIN; t++)
			@(posedge clk_i);
		exp = SKIP_MIN + 3'h1;
		check(skip === exp, "first up");
		prev = 2'h0;
		repeat (EVAL - 11) @(posedge clk_i);
		for (int i = 0; i < 26; i++) begin
			seed = xs(seed);
			case (i)
				0, 1, 2: nxt = 2'h0;
				3, 5, 6: nxt = 2'h2;
				4: nxt = 2'h3;
				default: nxt = seed[1:0];
			endcase
			cat <= nxt;
			line_high <= seed[4];
			repeat (12) @(posedge clk_i);
			exp = nsk(exp, (nxt > prev) ? nxt : prev);
			check(skip === exp, "skip mixed");
			check(hyst_sel === line_high, "hyst sel");
			repeat (EVAL) @(posedge clk_i);
			exp = nsk(exp, nxt);
			check(skip === exp, "skip pure");
			prev = nxt;
			repeat (EVAL - 12) @(posedge clk_i);
		end
		$display("test skip counter done");
		valleys <= 4'hc;
		gap <= 8'h32;
		vm = 3'h0;
		repeat (4000) begin
			@(posedge clk_i);
			if (valley > vm)
				vm = valley;
		end
		check(vm === VALLEY_MAX, "valley peak");
		// clock enable low must hold every register, synchronisers included
		clk_en_i <= 1'b0;
		@(posedge clk_i);
		frz = {cs_mv, gate, skip, valley, phase, hyst_sel};
		repeat (300) @(posedge clk_i);
		check(frz === {cs_mv, gate, skip, valley, phase, hyst_sel}, "frozen");
		clk_en_i <= 1'b1;
		valleys <= 4'h0;
		r = rises;
		repeat (3 * OFFMAX + 200) @(posedge clk_i);
		check(rises - r >= 2, "max off");
		$display("test valley and max off done");
		ovp_len <= 10'(OVP_BLANK_CYC) - 10'ha;
		repeat (2 * OFFMAX) @(posedge clk_i);
		check(latched === 1'b0, "short ovp");
		ovp_len <= 10'(OVP_BLANK_CYC) + 10'ha;
		repeat (2 * OFFMAX) @(posedge clk_i);
		check(latched === 1'b1 && phase === VS_LATCHED && gate === 1'b0, "ovp");
		ovp_len <= 10'h0;
		repeat (OFFMAX) @(posedge clk_i);
		check(latched === 1'b1 && gate === 1'b0, "latch hold");
		$display("test overvoltage done");
		test_done;
	end
	initial begin
		#(CLK_PERIOD_NS * 60000);
		mismatches++;
		$display("MISMATCH %0t: watchdog", $time);
		test_done;
	end
endmodule
